// ---- ai3d_pkg.sv ----
// constants for the adaptive illumination and 3d sync block
// Behaviour
// - each input frame yields its own digital gain for red, green and blue
// - every pixel of a channel is multiplied by that channel's frame gain
// - gain is the largest whose clipped pixel count stays small
// - each led gets its own current, chosen with the gain per frame
// - gain times led power keeps the target colour balance and white point
// - power saving keeps brightness and lowers led power where gain compensates
// - brightness boost keeps led power and raises brightness by gain only
// - a software strength setting places operation between the two extremes
// - led power falls with content; nominal for white, minimum for black at zero strength
// - regions dimmer than average picture level get strong local gain
// - with 3d input, sync output aligns eye shutters with displayed frames
// - a general output keys the ir transmitter with the eye sync
// - light sync gives one pulse per frame while shutters closed, none if under e since the last
// - the illumination driver is told when to switch the source on
// - with both shutters closed the source stays off except the pulse
// - pulse offset alternates between base and base plus delta each frame
// - at 120 hz: width 20-32 us, base over 500, e over 2000 us
// - nominal width and delta scale inversely with rate; 98 hz gives 31.8 and 161.6
// - at 100 hz nominal width 31.2 us and delta 158.4 us
package ai3d_pkg;
	localparam int unsigned CLK_NS = 5;
	localparam int unsigned NLVL   = 4;
	localparam int unsigned TW     = 20;

	localparam logic [NLVL-1:0][7:0] LVL_TAB  = {8'he0, 8'hc0, 8'ha0, 8'h80};
	localparam logic [NLVL-1:0][9:0] GAIN_TAB = {10'h124, 10'h155, 10'h19a,
		10'h200};
	localparam logic [NLVL-1:0][8:0] INV_TAB  = {9'h0e0, 9'h0c0, 9'h0a0, 9'h080};
	localparam logic [9:0] GAIN_UNITY = 10'h100;
	localparam logic [8:0] INV_UNITY  = 9'h100;
	localparam logic [8:0] LG_UNITY   = 9'h100;

	localparam logic [1:0] RATE_98  = 2'h0;
	localparam logic [1:0] RATE_100 = 2'h1;
	localparam logic [1:0] RATE_120 = 2'h2;

	localparam int unsigned A98_NS  = 31800;
	localparam int unsigned D98_NS  = 161600;
	localparam int unsigned A100_NS = 31200;
	localparam int unsigned D100_NS = 158400;
	localparam int unsigned A120_NS = 26000;
	localparam int unsigned D120_NS = 132000;
	localparam int unsigned B_NS    = 500000;
	localparam int unsigned E_NS    = 2000000;

	localparam int unsigned A98_CYC  = (A98_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned D98_CYC  = (D98_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned A100_CYC = (A100_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned D100_CYC = (D100_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned A120_CYC = (A120_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned D120_CYC = (D120_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned B_CYC_MIN = B_NS / CLK_NS + 1;
	localparam int unsigned E_CYC_MIN = E_NS / CLK_NS + 1;
endpackage : ai3d_pkg

// ---- pix_skid2.sv ----
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module pix_skid2 #(
	parameter int unsigned W = 26
) (
	input  wire logic         clk_sys_in,
	input  wire logic         reset_in,
	input  wire logic         in_valid_in,
	output logic              in_ready_out,
	input  wire logic [W-1:0] in_data_in,
	output logic              out_valid_out,
	input  wire logic         out_ready_in,
	output logic [W-1:0]      out_data_out
);
	typedef struct packed {
		logic [1:0][W-1:0] mem;
		logic [1:0]        cnt;
		logic              in_rdy;
		logic              out_vld;
	} buf_t;

	buf_t st_reg;
	buf_t st_next;

	always_comb begin
		logic push;
		logic pop;
		logic [1:0] c;
		push = in_valid_in & st_reg.in_rdy;
		pop = st_reg.out_vld & out_ready_in;
		c = st_reg.cnt;
		st_next = st_reg;
		if (pop) begin
			st_next.mem[0] = st_reg.mem[1];
			c = c - 2'h1;
		end
		if (push) begin
			st_next.mem[c[0]] = in_data_in;
			c = c + 2'h1;
		end
		st_next.cnt = c;
		st_next.in_rdy = (c != 2'h2);
		st_next.out_vld = (c != 2'h0);
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			st_reg <= '0;
			st_reg.in_rdy <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign in_ready_out  = st_reg.in_rdy;
	assign out_valid_out = st_reg.out_vld;
	assign out_data_out  = st_reg.mem[0];
endmodule : pix_skid2
`default_nettype wire

// ---- adaptive_illumination_3d_sync.sv ----
// frame gains, led currents, local boost and 3d eye sync
`timescale 1ns/1ps
`default_nettype none
module adaptive_illumination_3d_sync import ai3d_pkg::*; #(
	parameter int unsigned NB         = 4,
	parameter int unsigned BANDW      = 480,
	parameter int unsigned CNTW       = 22,
	parameter int unsigned CLIP_ALLOW = 16,
	parameter int unsigned LED_W      = 10,
	parameter logic [LED_W-1:0] LED_NOM = 10'h300,
	parameter logic [LED_W-1:0] LED_MIN = 10'h040,
	parameter int unsigned B_CYC      = B_CYC_MIN,
	parameter int unsigned E_CYC      = E_CYC_MIN,
	parameter int unsigned A_CYC [3]  = '{A98_CYC, A100_CYC, A120_CYC},
	parameter int unsigned D_CYC [3]  = '{D98_CYC, D100_CYC, D120_CYC}
) (
	input  wire logic             clk_sys_in,
	input  wire logic             reset_in,
	input  wire logic             pix_valid_in,
	output logic                  pix_ready_out,
	input  wire logic             pix_sof_in,
	input  wire logic             pix_eol_in,
	input  wire logic [7:0]       pix_r_in,
	input  wire logic [7:0]       pix_g_in,
	input  wire logic [7:0]       pix_b_in,
	output logic                  pix_valid_out,
	input  wire logic             pix_ready_in,
	output logic                  pix_sof_out,
	output logic                  pix_eol_out,
	output logic [7:0]            pix_r_out,
	output logic [7:0]            pix_g_out,
	output logic [7:0]            pix_b_out,
	input  wire logic [7:0]       ai_strength_in,
	input  wire logic [7:0]       lab_strength_in,
	input  wire logic             mode_3d_in,
	input  wire logic             sync_light_in,
	input  wire logic [1:0]       frame_rate_in,
	output logic [LED_W-1:0]      led_red_out,
	output logic [LED_W-1:0]      led_green_out,
	output logic [LED_W-1:0]      led_blue_out,
	output logic                  ir_sync_out,
	output logic                  illum_on_out,
	output logic                  sync_pulse_out
);
	localparam int unsigned BW   = (NB > 1) ? $clog2(NB) : 1;
	localparam int unsigned XW   = $clog2(BANDW + 1);
	localparam int unsigned SUMW = 32;

	typedef struct packed {
		logic [2:0][NLVL-1:0][CNTW-1:0] cnt;
		logic [2:0][7:0]                peak;
		logic [2:0][9:0]                gain;
		logic [2:0][LED_W-1:0]          led;
		logic [NB-1:0][SUMW-1:0]        bsum;
		logic [SUMW-1:0]                tsum;
		logic [NB-1:0]                  boost;
		logic [XW-1:0]                  x;
		logic [BW-1:0]                  band;
		logic                           eye;
		logic                           closed;
		logic                           pulse;
		logic                           armed;
		logic                           ir;
		logic                           illum;
		logic [TW-1:0]                  timer;
		logic [TW-1:0]                  since;
	} st_t;

	st_t st_reg;
	st_t st_next;

	logic [2:0][7:0] dout;
	logic            buf_rdy;
	logic [25:0]     bdata;
	logic [1:0]      ridx;
	logic [TW-1:0]   a_sel;
	logic [TW-1:0]   d_sel;
	logic            acc;

	assign ridx  = (frame_rate_in == 2'h3) ? RATE_120 : frame_rate_in;
	assign a_sel = TW'(A_CYC[ridx]);
	assign d_sel = TW'(D_CYC[ridx]);
	assign acc   = pix_valid_in & buf_rdy;

	always_comb begin
		logic [2:0][7:0]   px;
		logic [9:0]        luma;
		logic [8:0]        w;
		logic [8:0]        inv;
		logic [8:0]        lg;
		logic [9:0]        gsel;
		logic [LED_W-1:0]  sv;
		logic [LED_W+8:0]  pr;
		logic [26:0]       pp;
		logic [10:0]       sh;
		logic [TW-1:0]     off;
		st_next = st_reg;
		px = {pix_r_in, pix_g_in, pix_b_in};
		luma = {2'h0, px[2]} + {1'b0, px[1], 1'b0} + {2'h0, px[0]};
		w = {1'b0, ai_strength_in} + {8'h00, ai_strength_in[7]};
		inv = INV_UNITY;
		gsel = GAIN_UNITY;
		sv = '0;
		pr = '0;
		pp = '0;
		sh = '0;
		dout = '0;
		lg = st_reg.boost[st_reg.band] ? LG_UNITY + {1'b0, lab_strength_in}
			: LG_UNITY;
		off = TW'(B_CYC) + (st_reg.eye ? d_sel : '0);
		// per-channel product with saturation at full scale
		for (int c = 0; c < 3; c++) begin
			pp = 27'(px[c]) * 27'(st_reg.gain[c]) * 27'(lg);
			sh = pp[26:16];
			dout[c] = (sh > 11'h0ff) ? 8'hff : sh[7:0];
		end
		// frame boundary: derive gains and currents from last frame
		if (acc && pix_sof_in) begin
			for (int c = 0; c < 3; c++) begin
				gsel = GAIN_UNITY;
				inv = INV_UNITY;
				for (int i = NLVL - 1; i >= 0; i--) begin
					if (st_reg.cnt[c][i] <= CNTW'(CLIP_ALLOW)) begin
						gsel = GAIN_TAB[i];
						inv = INV_TAB[i];
					end
				end
				st_next.gain[c] = gsel;
				// saving current scales by inverse gain, keeping balance
				pr = (LED_W+9)'(LED_NOM) * (LED_W+9)'(inv);
				sv = pr[LED_W+7:8];
				if (st_reg.peak[c] == 8'h00 || sv < LED_MIN) begin
					sv = LED_MIN;
				end
				// strength blends between saving and boost current
				pr = (LED_W+9)'(LED_NOM - sv) * (LED_W+9)'(w);
				st_next.led[c] = sv + pr[LED_W+7:8];
			end
			for (int b = 0; b < NB; b++) begin
				st_next.boost[b] = ({st_reg.bsum[b], {BW{1'b0}}}
					< {{BW{1'b0}}, st_reg.tsum});
			end
			st_next.cnt = '0;
			st_next.peak = '0;
			st_next.bsum = '0;
			st_next.tsum = '0;
			st_next.x = '0;
			st_next.band = '0;
		end
		// statistics of the accepted pixel
		if (acc) begin
			for (int c = 0; c < 3; c++) begin
				for (int i = 0; i < NLVL; i++) begin
					if (px[c] > LVL_TAB[i] && !(&st_next.cnt[c][i])) begin
						st_next.cnt[c][i] = st_next.cnt[c][i] + 1'b1;
					end
				end
				if (px[c] > st_next.peak[c]) begin
					st_next.peak[c] = px[c];
				end
			end
			st_next.bsum[st_next.band] = st_next.bsum[st_next.band]
				+ SUMW'(luma);
			st_next.tsum = st_next.tsum + SUMW'(luma);
			if (pix_eol_in) begin
				st_next.x = '0;
				st_next.band = '0;
			end else if (st_next.x == XW'(BANDW - 1)) begin
				st_next.x = '0;
				if (st_next.band != BW'(NB - 1)) begin
					st_next.band = st_next.band + 1'b1;
				end
			end else begin
				st_next.x = st_next.x + 1'b1;
			end
		end
		// 3d eye sync and light pulse timing
		if (st_reg.since != {TW{1'b1}}) begin
			st_next.since = st_reg.since + 1'b1;
		end
		if (!mode_3d_in) begin
			st_next.eye = 1'b0;
			st_next.closed = 1'b0;
			st_next.pulse = 1'b0;
			st_next.timer = '0;
		end else if (acc && pix_sof_in) begin
			st_next.eye = !st_reg.eye;
			st_next.timer = '0;
			st_next.closed = sync_light_in;
			st_next.armed = (st_reg.since >= TW'(E_CYC));
			st_next.pulse = 1'b0;
		end else if (st_reg.closed) begin
			st_next.timer = st_reg.timer + 1'b1;
			if (st_reg.armed && st_reg.timer == off) begin
				st_next.pulse = 1'b1;
				st_next.armed = 1'b0;
				st_next.since = '0;
			end
			if (st_reg.timer == off + a_sel) begin
				st_next.pulse = 1'b0;
				st_next.closed = 1'b0;
			end
		end
		st_next.ir = mode_3d_in & !sync_light_in & st_next.eye;
		st_next.illum = !st_next.closed | st_next.pulse;
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			st_reg <= '0;
			st_reg.gain <= {3{GAIN_UNITY}};
			st_reg.led <= {3{LED_NOM}};
			st_reg.illum <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	pix_skid2 #(
		.W(26)
	) u_buf (
		.clk_sys_in   (clk_sys_in),
		.reset_in     (reset_in),
		.in_valid_in  (pix_valid_in),
		.in_ready_out (buf_rdy),
		.in_data_in   ({pix_sof_in, pix_eol_in, dout[2], dout[1], dout[0]}),
		.out_valid_out(pix_valid_out),
		.out_ready_in (pix_ready_in),
		.out_data_out (bdata)
	);

	assign pix_ready_out  = buf_rdy;
	assign pix_sof_out    = bdata[25];
	assign pix_eol_out    = bdata[24];
	assign pix_r_out      = bdata[23:16];
	assign pix_g_out      = bdata[15:8];
	assign pix_b_out      = bdata[7:0];
	assign led_red_out    = st_reg.led[2];
	assign led_green_out  = st_reg.led[1];
	assign led_blue_out   = st_reg.led[0];
	assign ir_sync_out    = st_reg.ir;
	assign illum_on_out   = st_reg.illum;
	assign sync_pulse_out = st_reg.pulse;

	// helper counters for pulse width and pulses per frame
	logic [TW-1:0] pw_reg;
	logic [1:0]    ppf_reg;

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			pw_reg <= '0;
			ppf_reg <= 2'h0;
		end else begin
			if (st_reg.pulse) begin
				pw_reg <= pw_reg + 1'b1;
			end else if (st_next.pulse) begin
				pw_reg <= '0;
			end
			if (acc && pix_sof_in) begin
				ppf_reg <= 2'h0;
			end else if (st_next.pulse && !st_reg.pulse && ppf_reg != 2'h3) begin
				ppf_reg <= ppf_reg + 2'h1;
			end
		end
	end

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (reset_in);

	sequence s_frame;
		acc && pix_sof_in;
	endsequence

	sequence s_frame_3d;
		s_frame and mode_3d_in;
	endsequence

	chk_eye_toggle: assert property (s_frame_3d |=> st_reg.eye != $past(st_reg.eye))
		else $error("eye flag did not toggle at frame start");
	chk_ir_eye: assert property ((mode_3d_in && !sync_light_in) |=> ir_sync_out == st_reg.eye)
		else $error("ir sync does not follow eye flag");
	chk_pulse_width: assert property ($fell(st_reg.pulse) && mode_3d_in && $stable(frame_rate_in) |-> pw_reg == a_sel)
		else $error("sync pulse width wrong");
	chk_dark_closed: assert property (s_frame_3d ##0 sync_light_in |=> !illum_on_out)
		else $error("illumination on while shutters closed");
	chk_one_pulse: assert property (s_frame |-> ppf_reg <= 2'h1)
		else $error("more than one pulse in a frame");
	chk_pulse_offset: assert property ($rose(st_reg.pulse) |-> st_reg.timer == TW'(B_CYC) + (st_reg.eye ? d_sel : '0) + 1'b1)
		else $error("pulse offset does not match eye");
	chk_clip_unity: assert property (s_frame ##0 (st_reg.cnt[2][NLVL-1] > CNTW'(CLIP_ALLOW)) |=> st_reg.gain[2] == GAIN_UNITY)
		else $error("gain raised despite clipping");
	chk_black_min: assert property (s_frame ##0 (st_reg.peak[2] == 8'h00 && ai_strength_in == 8'h00) |=> led_red_out == LED_MIN)
		else $error("black frame not at minimum current");
	chk_boost_nom: assert property (s_frame ##0 (ai_strength_in == 8'hff) |=> led_red_out == LED_NOM)
		else $error("boost mode changed led current");
endmodule : adaptive_illumination_3d_sync
`default_nettype wire

// ---- illum_sink_model.sv ----
// downstream pixel sink and illumination driver model
`timescale 1ns/1ps
`default_nettype none
module illum_sink_model (
	input  wire logic       clk_sys_in,
	input  wire logic       valid_in,
	input  wire logic [7:0] r_in,
	input  wire logic       stall_in,
	input  wire logic       pulse_in,
	input  wire logic       illum_in,
	output logic            ready_out,
	output var logic [7:0]  last_out = 8'h00,
	output var int unsigned count_out = 0,
	output var int unsigned pulses_out = 0
);
	logic pulse_reg = 1'b0;
	assign ready_out = !stall_in;
	always @(posedge clk_sys_in) begin
		if (valid_in && ready_out) begin
			last_out <= r_in;
			count_out <= count_out + 1;
		end
		// source lit for a pulse rise counts one sync flash
		if (pulse_in && !pulse_reg && illum_in)
			pulses_out <= pulses_out + 1;
		pulse_reg <= pulse_in;
	end
endmodule : illum_sink_model
`default_nettype wire

// ---- tb_adaptive_illumination_3d_sync.sv ----
// testbench for the adaptive illumination and 3d sync block
`timescale 1ns/1ps
`default_nettype none
module tb_adaptive_illumination_3d_sync;
	import ai3d_pkg::*;
	logic clk = 0, rst = 1, v = 0, sof = 0, stall = 0;
	logic m3d = 0, light = 0, rdy, vo, so, eo, ir, ill, pul;
	logic [7:0] r = 0, gv = 8'hff, ai = 8'h00, lab = 8'h00;
	logic [7:0] ro, go, bo;
	logic [1:0] rate = 2'h0;
	logic [9:0] lr, lg, lb;
	logic prdy;
	logic [7:0] last;
	int unsigned cnt, npul, cyc = 0;
	int n_errors = 0, n_tests = 0;

	adaptive_illumination_3d_sync #(.BANDW(5), .B_CYC(20), .E_CYC(10),
		.A_CYC('{4, 4, 4}), .D_CYC('{8, 8, 8})) DUT (
		.clk_sys_in(clk), .reset_in(rst), .pix_valid_in(v),
		.pix_ready_out(rdy), .pix_sof_in(sof), .pix_eol_in(1'b0),
		.pix_r_in(r), .pix_g_in(gv), .pix_b_in(r),
		.pix_valid_out(vo), .pix_ready_in(prdy), .pix_sof_out(so),
		.pix_eol_out(eo), .pix_r_out(ro), .pix_g_out(go),
		.pix_b_out(bo), .ai_strength_in(ai), .lab_strength_in(lab),
		.mode_3d_in(m3d), .sync_light_in(light), .frame_rate_in(rate),
		.led_red_out(lr), .led_green_out(lg), .led_blue_out(lb),
		.ir_sync_out(ir), .illum_on_out(ill), .sync_pulse_out(pul));

	illum_sink_model sink (.clk_sys_in(clk), .valid_in(vo), .r_in(ro),
		.stall_in(stall), .pulse_in(pul), .illum_in(ill),
		.ready_out(prdy), .last_out(last), .count_out(cnt),
		.pulses_out(npul));

	initial begin
		forever #2.5 clk = ~clk;
	end

	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		n_tests++;
		if (s !== e) begin
			n_errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk

	task automatic final_report;
		if (n_errors == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			final_report();
		end
	end

	task automatic px(input logic f, input logic [7:0] p);
		sof = f;
		r = p;
		v = 1;
		while (rdy !== 1'b1) @(negedge clk);
		@(negedge clk);
	endtask : px

	// twenty pixel frame whose last hi pixels are full scale
	task automatic frame(input logic [7:0] p, input int hi);
		for (int i = 0; i < 20; i++)
			px(i == 0, (i >= 20 - hi) ? 8'hff : p);
	endtask : frame

	task automatic next_px(input logic [9:0] led, input logic [7:0] o);
		px(1, 8'h70);
		chk(lr, led);
		chk(lb, led);
		chk(lg, 10'h300);
		px(0, 8'h70);
		v = 0;
		repeat (3) @(negedge clk);
		chk(last, o);
	endtask : next_px

	task automatic t_reset;
		chk({lr, rdy, vo, ir, ill, pul}, {10'h300, 5'b10010});
	endtask : t_reset

	task automatic t_gain;
		frame(8'h70, 16);
		next_px(10'h180, 8'he0);
		frame(8'h70, 17);
		next_px(10'h300, 8'h70);
		frame(8'h00, 0);
		next_px(10'h040, 8'he0);
		ai = 8'hff;
		frame(8'h70, 0);
		next_px(10'h300, 8'he0);
		ai = 8'h80;
		frame(8'h70, 0);
		next_px(10'h241, 8'he0);
	endtask : t_gain

	task automatic t_boost;
		frame(8'h00, 5);
		lab = 8'h80;
		next_px(10'h241, 8'hff);
		lab = 8'h00;
	endtask : t_boost

	task automatic t_stall;
		int unsigned c0;
		c0 = cnt;
		stall = 1;
		px(1, 8'h10);
		px(0, 8'h20);
		v = 0;
		@(negedge clk);
		chk(rdy, 1'b0);
		chk({vo, so, eo}, 3'b110);
		chk(bo, 8'h20);
		chk(go, 8'hff);
		stall = 0;
		repeat (4) @(negedge clk);
		chk(cnt - c0, 2);
		chk(last, 8'h40);
	endtask : t_stall

	task automatic pulse_frame(output int off);
		int wid;
		int unsigned p0;
		p0 = npul;
		px(1, 8'h40);
		v = 0;
		off = 0;
		wid = 0;
		chk(ill, 1'b0);
		while (pul !== 1'b1 && off < 200) begin
			chk(ill, 1'b0);
			@(negedge clk);
			off++;
		end
		while (pul === 1'b1 && wid < 200) begin
			@(negedge clk);
			wid++;
		end
		chk(wid, 4);
		chk(ill, 1'b1);
		repeat (30) @(negedge clk);
		chk(npul - p0, 1);
	endtask : pulse_frame

	task automatic t_3d;
		int o1, o2;
		logic e0;
		m3d = 1;
		light = 1;
		for (int fr = 0; fr < 3; fr++) begin
			rate = fr[1:0];
			pulse_frame(o1);
			pulse_frame(o2);
			chk(o2 > o1 ? o2 - o1 : o1 - o2, 8);
			chk(o2 > 20 || o1 > 20, 1'b1);
		end
		light = 0;
		e0 = ir;
		px(1, 8'h40);
		v = 0;
		@(negedge clk);
		chk(ir, !e0);
		px(1, 8'h40);
		v = 0;
		@(negedge clk);
		chk(ir, e0);
	endtask : t_3d

	initial begin
		repeat (10) @(negedge clk);
		rst = 0;
		@(negedge clk);
		t_reset();
		t_gain();
		t_boost();
		t_stall();
		t_3d();
		final_report();
	end
endmodule : tb_adaptive_illumination_3d_sync
`default_nettype wire
